// *** hdl/ppsc_pkg.sv ***
// Package with register map, field layout and types of the phase and spread control block.
package ppsc_pkg;
    localparam int NOUT = 4;
    localparam int AW = 6;
    // Register byte offsets.
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_LOOP = 6'h04;
    localparam logic [5:0] OFS_SUB_INTEGER_BITS = 6'h08;
    localparam logic [5:0] OFS_OUT0 = 6'h0C;
    localparam logic [5:0] OFS_STAT = 6'h1C;
    localparam logic [5:0] OFS_POS0 = 6'h20;
    localparam logic [5:0] OFS_MINT = 6'h30;
    localparam logic [5:0] OFS_MFRC = 6'h34;
    localparam logic [5:0] OFS_MULT = 6'h38;
    // Control, loop and output register fields.
    localparam int CT_MODE = 0;
    localparam int CT_SUB_INTEGER_BITS = 2;
    localparam int CT_SSEN = 3;
    localparam int CT_DOWN = 4;
    localparam int CT_PRNG = 5;
    localparam int CT_SPRD = 6;
    localparam int CT_FBSL = 11;
    localparam int CT_CASC = 13;
    localparam int LP_RFDV = 12;
    localparam int OC_PHAS = 7;
    localparam int OC_HOLD = 10;
    // Reset values.
    localparam logic [11:0] RST_LOOP_DIVIDE_VALUE = 12'h014;
    localparam logic [5:0] RST_INPUT_DIVIDE_VALUE = 6'h01;
    localparam logic [6:0] RST_PDIV = 7'h01;
    // Loop divide legal range in external feedback mode.
    localparam logic [11:0] EXT_FB_MIN = 12'h001;
    localparam logic [11:0] EXT_FB_MAX = 12'h4E2;
    // Spread arithmetic: depth is code times 0.1 percent, 1049/2^20 approximates 1/1000.
    localparam int SUB_INTEGER_BITS_BITS = 24;
    localparam logic [10:0] PERMILLE_K = 11'h419;
    localparam int PERMILLE_SH = 20;
    localparam logic [6:0] TRI_TOP = 7'h40;
    localparam int TRI_SH_DOWN = 6;
    localparam int TRI_SH_CTR = 5;
    localparam logic [6:0] LFSR_SEED = 7'h5A;
    localparam logic [2:0] PHASE_LAST = 3'h7;
    localparam logic [1:0] STOP_EDGES = 2'h2;

    typedef enum logic [1:0] {FB_POST_VCO, FB_POST_DIV, FB_EXTERNAL} ppsc_fb_mode_t;

    // Static setting of one output.
    typedef struct packed {
        logic [2:0] hold;
        logic [2:0] phase;
        logic [6:0] pdiv;
    } ppsc_out_cfg_t;

    // Dynamic phase position of one output: whole cycles and eighth steps.
    typedef struct packed {
        logic [6:0] coarse;
        logic [2:0] tap;
    } ppsc_pos_t;
endpackage

// *** hdl/ppsc_top.sv ***
// Phase selection, rotation, feedback mode and spread modulation control of a synthesis loop.
// How it works
// RL1 - Each output picks one of eight 45 degree oscillator phases on its own.
// RL2 - Each output can wait zero to seven quarter-rate cycles by holding its divider.
// RL3 - Phase tap and hold-off apply together on the same output.
// RL4 - Four select inputs mark which outputs a rotation moves.
// RL5 - One shared direction input: low rotates back, high rotates forward.
// RL6 - Each rotate rising edge moves every selected output by one phase step.
// RL7 - Sleep low or a falling restore edge reloads the programmed phases.
// RL8 - Rotations walk all eight steps of every cycle across the divided period.
// RL9 - Fabric must stop an output before changing its phase.
// RL10 - Configuring party keeps oscillator between 800 and 5000 MHz.
// RL11 - Three feedback modes; post-dividers always run from the quarter-rate clock.
// RL12 - Feedback divide is integer value, plus fraction over 2^24 in fractional mode.
// RL13 - Post-oscillator mode: ratio is loop divide; outputs divide by their post value.
// RL14 - Post-oscillator mode holds outputs low until lock, then restarts them together.
// RL15 - Post-divider mode multiplies by four times that divider; no restart on lock.
// RL16 - Third and fourth dividers cascade for up to 127 times 127 division.
// RL17 - External mode feeds one output back; loop divide 1 to 1250 is legal.
// RL18 - In external mode fabric performs any restart-on-lock alignment.
// RL19 - Spread modulation only runs in fractional mode with spread enabled.
// RL20 - Modulator varies integer and fraction; center or down; triangle or random.
// RL21 - Depth code 0 disables, 1 is least, 31 most; depth is code times 0.1%.
// RL22 - Center spread swings both ways by depth; down spread only below nominal.
// RL23 - After stop falls, output goes low after the second falling divider edge.
// RL24 - Lock rises only when both frequency and phase lock are present.
// RL25 - Rotate and restore are synchronised and edge detected, one action per edge.
// RL26 - Depth code is a five bit unsigned field.
//
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
module ppsc_top (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic adjust_target_0,
    input wire logic adjust_target_1,
    input wire logic adjust_target_2,
    input wire logic adjust_target_3,
    input wire logic rotate_forward,
    input wire logic rotate_strobe,
    input wire logic restore_n,
    input wire logic loop_sleep_n,
    input wire logic freq_locked,
    input wire logic phase_locked,
    input wire logic [3:0] out_run,
    output logic loop_locked,
    output logic [3:0] out_clk,
    output logic [11:0] phase_tap,
    output logic [11:0] mod_int,
    output logic [23:0] mod_sub_integer_bits
);
    // Control registers written by software, then bus, lock, synchroniser and spread state.
    logic [13:0] ctrl_ff;
    logic [17:0] loop_ff;
    logic [23:0] sub_integer_bits_ff;
    ppsc_pkg::ppsc_out_cfg_t cfg_ff [ppsc_pkg::NOUT];
    logic [31:0] rdata_ff;
    logic ack_ff;
    logic lock_ff;
    logic lock_q_ff;
    logic [2:0] rot_sync_ff;
    logic [2:0] rst_sync_ff;
    logic [1:0] slp_sync_ff;
    logic [6:0] tri_ff;
    logic tri_up_ff;
    logic [6:0] lfsr_ff;
    logic [35:0] mod_ff;

    // Decoded control fields.
    wire ppsc_pkg::ppsc_fb_mode_t fb_mode =
        ppsc_pkg::ppsc_fb_mode_t'(ctrl_ff[ppsc_pkg::CT_MODE +: 2]);
    wire sub_integer_bits_mode = ctrl_ff[ppsc_pkg::CT_SUB_INTEGER_BITS];
    wire ss_en = ctrl_ff[ppsc_pkg::CT_SSEN];
    wire ss_down = ctrl_ff[ppsc_pkg::CT_DOWN];
    wire ss_prng = ctrl_ff[ppsc_pkg::CT_PRNG];
    wire [4:0] spread_code = ctrl_ff[ppsc_pkg::CT_SPRD +: 5]; // see RL26
    wire [1:0] fb_sel = ctrl_ff[ppsc_pkg::CT_FBSL +: 2];
    wire cascade = ctrl_ff[ppsc_pkg::CT_CASC];
    wire [11:0] loop_divide_value = loop_ff[11:0];
    wire [5:0] input_divide_value = loop_ff[ppsc_pkg::LP_RFDV +: 6];
    wire [23:0] sub_integer_bits = sub_integer_bits_mode ? sub_integer_bits_ff : 24'h000000; // see RL12
    wire [3:0] adjust_target = {adjust_target_3, adjust_target_2,
                                adjust_target_1, adjust_target_0}; // see RL4

    // Bus decode and byte lane mask.
    wire wr_go = avs_write && !avs_read;
    wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                           {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [31:0] wr_ctrl = ({18'h00000, ctrl_ff} & ~be_mask) | (avs_writedata & be_mask);
    wire [31:0] wr_loop = ({14'h0000, loop_ff} & ~be_mask) | (avs_writedata & be_mask);
    wire [31:0] wr_sub_integer_bits = ({8'h00, sub_integer_bits_ff} & ~be_mask) | (avs_writedata & be_mask);
    wire [3:0] sel_out;
    assign avs_waitrequest = avs_read && !ack_ff;
    assign avs_readdata = rdata_ff;

    // Edge detection after two-stage synchronisers.
    wire rotate_rise = rot_sync_ff[1] && !rot_sync_ff[2]; // see RL25
    wire restore_fall = !rst_sync_ff[1] && rst_sync_ff[2]; // see RL25
    wire sleeping = !slp_sync_ff[1];
    wire reload = sleeping || restore_fall; // see RL7
    wire lock_rise = lock_ff && !lock_q_ff;
    wire post_vco = (fb_mode == ppsc_pkg::FB_POST_VCO);
    // Outputs restart together on lock in post-oscillator mode only.
    wire div_restart = sleeping || (post_vco && lock_rise); // see RL14, RL15, RL18
    wire out_allow = !sleeping && (!post_vco || lock_ff); // see RL14

    // Loop multiplier seen by the oscillator over the reference divided by the input divider.
    wire [6:0] fb_pdiv = cfg_ff[fb_sel].pdiv;
    wire [20:0] mult_post_div = 21'(loop_divide_value * fb_pdiv) << 2;
    wire [20:0] loop_mult = post_vco ? {9'h000, loop_divide_value} : mult_post_div; // see RL13, RL15
    wire ext_range_err = (fb_mode == ppsc_pkg::FB_EXTERNAL) &&
                         ((loop_divide_value < ppsc_pkg::EXT_FB_MIN) ||
                          (loop_divide_value > ppsc_pkg::EXT_FB_MAX)); // see RL17

    // Spread arithmetic on the nominal divide value in 12.24 fixed point.
    wire [35:0] nominal = {loop_divide_value, sub_integer_bits};
    wire [40:0] n_code = 41'(nominal * spread_code);
    wire [51:0] n_k = 52'(n_code * ppsc_pkg::PERMILLE_K);
    wire [35:0] depth = 36'(n_k >> ppsc_pkg::PERMILLE_SH); // see RL21
    wire [6:0] profile = ss_prng ? {1'b0, lfsr_ff[5:0]} : tri_ff; // see RL20
    wire [42:0] dev_prof = 43'(depth * profile);
    wire [35:0] swing = ss_down ? 36'(dev_prof >> ppsc_pkg::TRI_SH_DOWN)
                                : 36'(dev_prof >> ppsc_pkg::TRI_SH_CTR);
    // Center spans nominal-depth to nominal+depth; down spans nominal-depth to nominal.
    wire [35:0] spread_div = nominal - depth + swing; // see RL22
    wire ss_active = sub_integer_bits_mode && ss_en && (spread_code != 5'h00); // see RL19, RL21
    wire [35:0] nxt_mod = ss_active ? spread_div : nominal;
    assign mod_int = mod_ff[35:24]; // see RL20
    assign mod_sub_integer_bits = mod_ff[23:0];

    // Read multiplexer over the register map.
    logic [31:0] rd_mux;
    ppsc_pkg::ppsc_pos_t pos_ff [ppsc_pkg::NOUT];
    logic [3:0] lvl_ff;
    always_comb begin
        rd_mux = 32'h00000000;
        case (avs_address)
            ppsc_pkg::OFS_CTRL: rd_mux = {18'h00000, ctrl_ff};
            ppsc_pkg::OFS_LOOP: rd_mux = {14'h0000, loop_ff};
            ppsc_pkg::OFS_SUB_INTEGER_BITS: rd_mux = {8'h00, sub_integer_bits_ff};
            ppsc_pkg::OFS_STAT: rd_mux = {24'h000000, out_clk, ext_range_err, 2'h0, lock_ff};
            ppsc_pkg::OFS_MINT: rd_mux = {20'h00000, mod_ff[35:24]};
            ppsc_pkg::OFS_MFRC: rd_mux = {8'h00, mod_ff[23:0]};
            ppsc_pkg::OFS_MULT: rd_mux = {11'h000, loop_mult};
            default: begin
                for (int k = 0; k < ppsc_pkg::NOUT; k++) begin
                    if (avs_address == ppsc_pkg::OFS_OUT0 + 6'(4 * k)) begin
                        rd_mux = {19'h00000, cfg_ff[k]};
                    end
                    if (avs_address == ppsc_pkg::OFS_POS0 + 6'(4 * k)) begin
                        rd_mux = {22'h000000, pos_ff[k]};
                    end
                end
            end
        endcase
    end

    // Read answer one cycle after the request; writes complete with no wait.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
        end else begin
            ack_ff <= avs_read && !ack_ff;
            if (avs_read && !ack_ff) begin
                rdata_ff <= rd_mux;
            end
        end
    end

    // Shared control registers.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_ff <= 14'h0000;
            loop_ff <= {ppsc_pkg::RST_INPUT_DIVIDE_VALUE, ppsc_pkg::RST_LOOP_DIVIDE_VALUE};
            sub_integer_bits_ff <= 24'h000000;
        end else if (wr_go) begin
            if (avs_address == ppsc_pkg::OFS_CTRL) begin
                ctrl_ff <= wr_ctrl[13:0];
            end
            if (avs_address == ppsc_pkg::OFS_LOOP) begin
                loop_ff <= wr_loop[17:0];
            end
            if (avs_address == ppsc_pkg::OFS_SUB_INTEGER_BITS) begin
                sub_integer_bits_ff <= wr_sub_integer_bits[23:0];
            end
        end
    end

    // Synchronisers, lock qualification and the spread profile.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rot_sync_ff <= 3'h0;
            rst_sync_ff <= 3'h7;
            slp_sync_ff <= 2'h0;
            lock_ff <= 1'b0;
            lock_q_ff <= 1'b0;
            tri_ff <= 7'h00;
            tri_up_ff <= 1'b1;
            lfsr_ff <= ppsc_pkg::LFSR_SEED;
            mod_ff <= 36'h000000000;
        end else begin
            rot_sync_ff <= {rot_sync_ff[1:0], rotate_strobe};
            rst_sync_ff <= {rst_sync_ff[1:0], restore_n};
            slp_sync_ff <= {slp_sync_ff[0], loop_sleep_n};
            lock_ff <= freq_locked && phase_locked && loop_sleep_n; // see RL24
            lock_q_ff <= lock_ff;
            lfsr_ff <= {lfsr_ff[5:0], lfsr_ff[6] ^ lfsr_ff[5]};
            if (tri_up_ff) begin
                tri_ff <= tri_ff + 7'h01;
                tri_up_ff <= (tri_ff + 7'h01) != ppsc_pkg::TRI_TOP;
            end else begin
                tri_ff <= tri_ff - 7'h01;
                tri_up_ff <= (tri_ff - 7'h01) == 7'h00;
            end
            mod_ff <= nxt_mod; // see RL20
        end
    end

    // Per-output phase position, divider, hold-off and glitch-free stop.
    genvar gi;
    generate
        for (gi = 0; gi < ppsc_pkg::NOUT; gi++) begin : g_out
            logic [6:0] cnt_ff;
            logic [2:0] hold_ff;
            logic tog_ff;
            logic gate_ff;
            logic [1:0] fall_ff;
            logic wrap_ff;
            ppsc_pkg::ppsc_out_cfg_t nxt_cfg;
            ppsc_pkg::ppsc_pos_t nxt_pos;
            wire [6:0] pdiv = (cfg_ff[gi].pdiv == 7'h00) ? 7'h01 : cfg_ff[gi].pdiv;
            wire [6:0] last = pdiv - 7'h01;
            // Widened by one bit so that a divide of 127 does not wrap to a zero half period.
            wire [6:0] half = 7'(({1'b0, pdiv} + 8'h01) >> 1);
            // The fourth divider advances on the third divider's wrap when cascaded.
            wire tick = (gi == 3 && cascade) ? g_out[2].wrap_ff : 1'b1; // see RL16
            wire lvl = (pdiv == 7'h01) ? tog_ff : (cnt_ff < half);
            wire fell = lvl_ff[gi] && !lvl;
            wire [31:0] wr_cfg = ({19'h00000, cfg_ff[gi]} & ~be_mask) | (avs_writedata & be_mask);
            assign sel_out[gi] = (avs_address == ppsc_pkg::OFS_OUT0 + 6'(4 * gi));

            // Next dynamic position: taps carry into whole cycles of the divided period.
            always_comb begin
                nxt_pos = pos_ff[gi];
                if (reload) begin
                    nxt_pos.tap = cfg_ff[gi].phase; // see RL1, RL7
                    nxt_pos.coarse = 7'h00;
                end else if (rotate_rise && adjust_target[gi]) begin // see RL4, RL6
                    if (rotate_forward) begin // see RL5
                        nxt_pos.tap = pos_ff[gi].tap + 3'h1;
                        if (pos_ff[gi].tap == ppsc_pkg::PHASE_LAST) begin // see RL8
                            nxt_pos.coarse = (pos_ff[gi].coarse >= last) ? 7'h00
                                             : pos_ff[gi].coarse + 7'h01;
                        end
                    end else begin
                        nxt_pos.tap = pos_ff[gi].tap - 3'h1;
                        if (pos_ff[gi].tap == 3'h0) begin // see RL8
                            nxt_pos.coarse = (pos_ff[gi].coarse == 7'h00) ? last
                                             : pos_ff[gi].coarse - 7'h01;
                        end
                    end
                end
            end

            // Static configuration word of this output.
            always_comb begin
                nxt_cfg = cfg_ff[gi];
                if (wr_go && sel_out[gi]) begin
                    nxt_cfg = wr_cfg[12:0];
                end
            end

            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    cfg_ff[gi] <= {3'h0, 3'h0, ppsc_pkg::RST_PDIV};
                    pos_ff[gi] <= '0;
                end else begin
                    cfg_ff[gi] <= nxt_cfg;
                    pos_ff[gi] <= nxt_pos;
                end
            end

            // Divider on the quarter-rate clock, held for the hold-off count after a restart.
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    cnt_ff <= 7'h00;
                    hold_ff <= 3'h0;
                    tog_ff <= 1'b0;
                    wrap_ff <= 1'b0;
                end else if (div_restart || reload) begin
                    cnt_ff <= 7'h00;
                    hold_ff <= cfg_ff[gi].hold; // see RL2, RL3
                    tog_ff <= 1'b0;
                    wrap_ff <= 1'b0;
                end else if (hold_ff != 3'h0) begin
                    hold_ff <= hold_ff - 3'h1; // see RL2
                    wrap_ff <= 1'b0;
                end else begin
                    wrap_ff <= tick && (cnt_ff >= last);
                    if (tick) begin
                        cnt_ff <= (cnt_ff >= last) ? 7'h00 : cnt_ff + 7'h01; // see RL11
                        tog_ff <= !tog_ff;
                    end
                end
            end

            // Stop gate closes only after two falling edges of the divided clock.
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    lvl_ff[gi] <= 1'b0;
                    gate_ff <= 1'b0;
                    fall_ff <= 2'h0;
                end else begin
                    lvl_ff[gi] <= lvl;
                    if (out_run[gi]) begin
                        gate_ff <= !lvl || gate_ff;
                        fall_ff <= 2'h0;
                    end else if (gate_ff && fell) begin
                        fall_ff <= fall_ff + 2'h1;
                        if (fall_ff + 2'h1 == ppsc_pkg::STOP_EDGES) begin
                            gate_ff <= 1'b0; // see RL23
                        end
                    end
                end
            end

            assign out_clk[gi] = lvl_ff[gi] && gate_ff && out_allow; // see RL14
            assign phase_tap[gi * 3 +: 3] = pos_ff[gi].tap; // see RL1

            a_rot_step_fwd: assert property (@(posedge clk) disable iff (!rst_b)
                rotate_rise && adjust_target[gi] && rotate_forward && !reload
                |=> pos_ff[gi].tap == $past(pos_ff[gi].tap) + 3'h1) // see RL6
                else $error("forward rotation did not advance one tap");
            a_rot_step_back: assert property (@(posedge clk) disable iff (!rst_b)
                rotate_rise && adjust_target[gi] && !rotate_forward && !reload
                |=> pos_ff[gi].tap == $past(pos_ff[gi].tap) - 3'h1) // see RL5
                else $error("backward rotation did not retreat one tap");
            a_unsel_still: assert property (@(posedge clk) disable iff (!rst_b)
                !adjust_target[gi] && !reload |=> $stable(pos_ff[gi])) // see RL4
                else $error("unselected output moved");
            a_reload_phase: assert property (@(posedge clk) disable iff (!rst_b)
                reload |=> pos_ff[gi].tap == $past(cfg_ff[gi].phase)) // see RL7
                else $error("restore did not reload the programmed phase");
            a_hold_quiet: assert property (@(posedge clk) disable iff (!rst_b)
                hold_ff != 3'h0 && !div_restart && !reload |=> cnt_ff == 7'h00) // see RL2
                else $error("divider ran during hold-off");
        end
    endgenerate

    a_lock_both: assert property (@(posedge clk) disable iff (!rst_b)
        loop_locked |-> $past(freq_locked) && $past(phase_locked)) // see RL24
        else $error("lock shown without both locks");
    a_vco_mode_low: assert property (@(posedge clk) disable iff (!rst_b)
        post_vco && !lock_ff |-> out_clk == 4'h0) // see RL14
        else $error("output toggled before lock");
    a_spread_off: assert property (@(posedge clk) disable iff (!rst_b)
        !ss_active ##1 $stable(ctrl_ff) && $stable(loop_ff) && $stable(sub_integer_bits_ff)
        |-> mod_ff == nominal) // see RL19
        else $error("modulation present while spread inactive");
    a_down_below: assert property (@(posedge clk) disable iff (!rst_b)
        ss_active && ss_down |-> spread_div <= nominal) // see RL22
        else $error("down spread exceeded nominal");
    a_rot_once: assert property (@(posedge clk) disable iff (!rst_b)
        rotate_rise |=> !rotate_rise) // see RL25
        else $error("one strobe edge gave two rotations");

    c_rotate_fwd: cover property (@(posedge clk) disable iff (!rst_b)
        rotate_rise && rotate_forward && adjust_target != 4'h0);
    c_restore: cover property (@(posedge clk) disable iff (!rst_b) restore_fall);
    c_lock_restart: cover property (@(posedge clk) disable iff (!rst_b) post_vco && lock_rise);
    c_spread_run: cover property (@(posedge clk) disable iff (!rst_b) ss_active && !ss_down);

    assign loop_locked = lock_ff;
endmodule

// *** test/ppsc_fabric_model.sv ***
// Fabric-side model that stops outputs, rotates their phases and pulses restore.
module ppsc_fabric_model (
    input wire logic clk,
    output logic [3:0] sel = 4'h0,
    output logic fwd = 1'b0,
    output logic strobe = 1'b0,
    output logic restore_n = 1'b1,
    output logic [3:0] run = 4'hF
);
    timeunit 1ns;
    timeprecision 1ns;
    // Stops the targets, gives one rotate edge, then lets every output run again.
    task automatic rotate(input logic [3:0] s, input logic f);
        run <= run & ~s;
        repeat (4) @(posedge clk);
        sel <= s;
        fwd <= f;
        @(posedge clk);
        strobe <= 1'b1;
        repeat (2) @(posedge clk);
        strobe <= 1'b0;
        repeat (3) @(posedge clk);
        sel <= 4'h0;
        run <= 4'hF;
        @(posedge clk);
    endtask
    // Stops all outputs and pulses restore low to reload the programmed phases.
    task automatic restore();
        run <= 4'h0;
        restore_n <= 1'b0;
        repeat (3) @(posedge clk);
        restore_n <= 1'b1;
        run <= 4'hF;
        repeat (4) @(posedge clk);
    endtask
endmodule

// *** test/pll_phase_and_spread_control_tb.sv ***
// Self-checking bench of the phase and spread control block.
`define CHK(got, exp) check_eq(32'(got), 32'(exp))
module pll_phase_and_spread_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [35:0] NOM = 36'h032000000;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [5:0] adr = 6'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic sleep_n = 1'b1;
    logic flock = 1'b0;
    logic plock = 1'b0;
    logic [31:0] rdat, q;
    logic wait_q, locked, fwd, stb, rs_n;
    logic [3:0] sel, run, oclk;
    logic [11:0] tap, mint;
    logic [23:0] mfrc;
    logic [35:0] mx, mn;
    int failures = 0;
    int n_compared = 0;
    // The clock runs at 10 MHz.
    always #50 clk = ~clk;
    ppsc_top i_dut (
        .clk(clk), .rst_b(rst_b), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_byteenable(4'hF), .avs_writedata(wdat), .avs_readdata(rdat),
        .avs_waitrequest(wait_q), .adjust_target_0(sel[0]), .adjust_target_1(sel[1]),
        .adjust_target_2(sel[2]), .adjust_target_3(sel[3]), .rotate_forward(fwd),
        .rotate_strobe(stb), .restore_n(rs_n), .loop_sleep_n(sleep_n),
        .freq_locked(flock), .phase_locked(plock), .out_run(run), .loop_locked(locked),
        .out_clk(oclk), .phase_tap(tap), .mod_int(mint), .mod_sub_integer_bits(mfrc)
    );
    ppsc_fabric_model i_fab (
        .clk(clk), .sel(sel), .fwd(fwd), .strobe(stb), .restore_n(rs_n), .run(run)
    );
    // Compares one value and counts the outcome.
    task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // One bus cycle, held until waitrequest is sampled low; read data lands in q.
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int i;
        adr <= a;
        wdat <= d;
        rd <= ~w;
        wr <= w;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (wait_q === 1'b0) break;
        end
        q = rdat;
        if (i == 20) begin
            failures++;
            give_verdict();
        end
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    // Reads one register and compares it.
    task automatic rchk(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(q, e);
    endtask
    // Sets the control word, tracks the extremes of the modulated divide and checks them.
    task automatic spread(input logic [31:0] c, input logic up, input logic dn);
        bus(1'b1, ppsc_pkg::OFS_CTRL, c);
        repeat (4) @(posedge clk);
        mx = NOM;
        mn = NOM;
        repeat (140) begin
            @(posedge clk);
            if ({mint, mfrc} > mx) mx = {mint, mfrc};
            if ({mint, mfrc} < mn) mn = {mint, mfrc};
        end
        `CHK(mx > NOM, up);
        `CHK(mn < NOM, dn);
        `CHK(mx < 36'h032C10000, 1'b1);
        `CHK(mn > 36'h0313F0000, 1'b1);
    endtask
    // Main sequence: registers, phase moves, sleep, lock, modes and spread.
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        rchk(ppsc_pkg::OFS_LOOP, 32'h00001014);
        rchk(ppsc_pkg::OFS_OUT0, 32'h00000001);
        rchk(6'h3C, 32'h0);
        bus(1'b1, ppsc_pkg::OFS_OUT0, 32'h00000181);
        bus(1'b1, ppsc_pkg::OFS_OUT0 + 6'h04, 32'h00000802);
        i_fab.restore();
        `CHK(tap, 12'h003);
        i_fab.rotate(4'h1, 1'b1);
        `CHK(tap, 12'h004);
        i_fab.rotate(4'h3, 1'b0);
        `CHK(tap, 12'h03B);
        rchk(ppsc_pkg::OFS_POS0 + 6'h04, 32'h0000000F);
        repeat (9) i_fab.rotate(4'h2, 1'b1);
        rchk(ppsc_pkg::OFS_POS0 + 6'h04, 32'h00000008);
        sleep_n <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK(oclk, 4'h0);
        sleep_n <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK(tap, 12'h003);
        repeat (10) @(posedge clk);
        `CHK(oclk, 4'h0);
        flock <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK(locked, 1'b0);
        plock <= 1'b1;
        repeat (3) @(posedge clk);
        bus(1'b0, ppsc_pkg::OFS_STAT, 32'h0);
        `CHK(q[3:0], 4'h1);
        `CHK(q[7:4] != 4'h0, 1'b1);
        bus(1'b1, ppsc_pkg::OFS_LOOP, 32'h00001032);
        rchk(ppsc_pkg::OFS_MULT, 32'h00000032);
        bus(1'b1, ppsc_pkg::OFS_CTRL, 32'h00000001);
        rchk(ppsc_pkg::OFS_MULT, 32'h000000C8);
        bus(1'b1, ppsc_pkg::OFS_CTRL, 32'h00000801);
        rchk(ppsc_pkg::OFS_MULT, 32'h00000190);
        bus(1'b1, ppsc_pkg::OFS_CTRL, 32'h00000002);
        i_fab.restore();
        bus(1'b1, ppsc_pkg::OFS_LOOP, 32'h000014E3);
        bus(1'b0, ppsc_pkg::OFS_STAT, 32'h0);
        `CHK(q[3], 1'b1);
        bus(1'b1, ppsc_pkg::OFS_LOOP, 32'h000014E2);
        bus(1'b0, ppsc_pkg::OFS_STAT, 32'h0);
        `CHK(q[3], 1'b0);
        bus(1'b1, ppsc_pkg::OFS_LOOP, 32'h00001032);
        spread(32'h000003CC, 1'b1, 1'b1);
        spread(32'h000003DC, 1'b0, 1'b1);
        spread(32'h000003EC, 1'b1, 1'b1);
        spread(32'h000003C8, 1'b0, 1'b0);
        spread(32'h0000000C, 1'b0, 1'b0);
        give_verdict();
    end
endmodule
